// ### rtl/idle_reset_consts.svh
// Offsets, field positions, reset values and timing counts for idle and reset control.
// Assumes inclusion by bare name from the design files.
`ifndef IDLE_RESET_CONSTS_SVH
`define IDLE_RESET_CONSTS_SVH
// Register byte offsets on APB
`define OFS_SYSCTL 8'h00
`define OFS_TRAP 8'h04
`define OFS_ENABLE 8'h08
`define OFS_PENDING 8'h0C
`define OFS_CAUSE 8'h10
`define OFS_CORE 8'h14
// Field positions
`define SYSCTL_IDLE 0
`define SYSCTL_MIE 1
`define TRAP_ALLOW 0
`define CORE_JUMP 4
// Key that unlocks the trap allow bit (arbitrary value)
`define TRAP_KEY 8'hA5
// Reset values
`define ENABLE_RST 8'h00
`define BANK_RST 4'h0
`define JUMP_RST 1'b1
`define PRESC_RST 8'h00
// Reset vector locations
`define VEC_LO 20'hFFFFC
`define VEC_HI 20'hFFFFE
// Fetch regions that trip the address trap
`define RAM_LO 20'h00040
`define RAM_HI 20'h0083F
`define SFR_LO 20'h00000
`define SFR_HI 20'h0003F
`define EXT_LO 20'h00F00
`define EXT_HI 20'h00FFF
// Timing in fc periods; the clock is fc
`define MC_FC 4
`define RST_MIN_FC 12
`define RST_MIN_MC (`RST_MIN_FC / `MC_FC)
`define RST_HOLD_CYC 4'hC
`endif

// ### rtl/idle_reset_pkg.sv
// Types shared by the idle and reset control files.
// Assumes idle_reset_consts.svh supplies the numbers.
package idle_reset_pkg;
   typedef logic [19:0] addr_t;
   typedef enum logic [2:0] {ST_RESET = 3'b001, ST_RUN = 3'b010, ST_IDLE = 3'b100} mode_e;
   typedef struct packed {
      mode_e mode;
      logic mie;
      logic trap_allow;
      logic [7:0] enables;
      logic [7:0] pending;
      logic [4:0] causes;
      logic [3:0] bank;
      logic jump;
      logic [7:0] presc;
      addr_t resume_pc;
      logic [3:0] hold;
      logic rst_out;
      logic vec_fetch;
      logic irq_take;
      logic [2:0] irq_index;
      logic wake_inline;
      logic halt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ctl_s;
   typedef struct packed {
      logic sync0;
      logic sync1;
      logic [1:0] phase;
      logic mc_low;
      logic [1:0] low_mc;
      logic pin_reset;
   } filt_s;
endpackage

// ### rtl/reset_pin_filter.sv
// Synchronises the external reset pin and counts low machine cycles.
// Assumes reset_pin_n is asynchronous to sys_clk.
`include "idle_reset_consts.svh"
module reset_pin_filter (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic reset_pin_n,
   output logic pin_reset
);
   import idle_reset_pkg::*;
   filt_s r_reg;
   filt_s r_next;
   logic all_low;

   // Two-stage sync, machine-cycle phase and low-cycle count
   always_comb
   begin
      r_next = r_reg;
      all_low = r_reg.mc_low & ~r_reg.sync1;
      r_next.sync0 = reset_pin_n;
      r_next.sync1 = r_reg.sync0;
      r_next.phase = r_reg.phase + 2'h1;
      if (r_reg.sync1)
      begin
         r_next.low_mc = 2'h0;
         r_next.mc_low = 1'b0;
      end
      else if (r_reg.phase == 2'(`MC_FC - 1))
      begin
         r_next.mc_low = 1'b1;
         if (all_low && r_reg.low_mc != 2'(`RST_MIN_MC))
            r_next.low_mc = r_reg.low_mc + 2'h1;
      end
      else
         r_next.mc_low = all_low;
      r_next.pin_reset = ~r_reg.sync1 & (r_reg.pin_reset | (r_reg.low_mc == 2'(`RST_MIN_MC)));
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         r_reg <= '{sync0: 1'b1, sync1: 1'b1, phase: 2'h0, mc_low: 1'b0, low_mc: 2'h0,
                    pin_reset: 1'b0};
      else
         r_reg <= r_next;
   end

   assign pin_reset = r_reg.pin_reset;

   release_on_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      r_reg.sync1 |=> !pin_reset) else $error("pin reset held while pin high");
endmodule

// ### rtl/trap_detector.sv
// Flags instruction fetches from RAM, SPECIAL_FUNCTION_AREA or extended register areas.
// Assumes fetch_valid and fetch_addr come from the CPU on sys_clk.
`include "idle_reset_consts.svh"
module trap_detector (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic fetch_valid,
   input wire idle_reset_pkg::addr_t fetch_addr,
   input wire logic trap_allow,
   output logic trap_hit
);
   import idle_reset_pkg::*;
   logic hit_reg;
   logic hit_next;

   function automatic logic in_region(input addr_t a, input addr_t lo, input addr_t hi);
      in_region = (a >= lo) && (a <= hi);
   endfunction

   // Any fetch into a protected region while allowed
   always_comb
   begin
      hit_next = fetch_valid & trap_allow & (in_region(fetch_addr, `RAM_LO, `RAM_HI)
         | in_region(fetch_addr, `SFR_LO, `SFR_HI)
         | in_region(fetch_addr, `EXT_LO, `EXT_HI));
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         hit_reg <= 1'b0;
      else
         hit_reg <= hit_next;
   end

   assign trap_hit = hit_reg;

   no_hit_prohibited_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !trap_allow |=> !trap_hit) else $error("trap fired while prohibited");
endmodule

// ### rtl/idle_mode_and_reset_control.sv
// Idle mode control, reset cause combining and APB register file.
// Assumes CPU, interrupt sources and cause inputs share sys_clk; reset_pin_n is a pin.
//
// What this block does
// - In idle the CPU and watchdog halt; peripherals keep running.
// - Idle keeps memory, registers, status word and port latches unchanged.
// - Idle leaves the program counter two instructions past the idle request.
// - With master enable 0, an enabled source ends idle and resumes in line.
// - With master enable 1, an enabled source ends idle and vectors.
// - Reset pin low during idle resets at once, restarting in normal mode.
// - A watchdog interrupt just before idle is serviced; idle is not entered.
// - Five reset causes are combined into one internal reset.
// - Watchdog, trap and clock cause records are not cleared at power-on.
// - Reset clears bank, enables, prescaler and sets the jump flag.
// - Pin must stay low three machine cycles (12 fc) to reset.
// - On release, execution starts from the vector at FFFFC to FFFFE.
// - Allowed trap resets on fetches from RAM, SPECIAL_FUNCTION_AREA or extended areas.
// - Trap is allowed after reset; keyed software write can prohibit it.
// - Frequency detector out of range raises a reset.
// - Every pending latch clears on any reset.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`include "idle_reset_consts.svh"
module idle_mode_and_reset_control (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reset_pin_n,
   input wire logic wdt_reset_req,
   input wire logic sysclk_fault,
   input wire logic freq_below,
   input wire logic freq_above,
   input wire logic fetch_valid,
   input wire idle_reset_pkg::addr_t fetch_addr,
   input wire idle_reset_pkg::addr_t next2_pc,
   input wire logic [7:0] irq_src,
   output logic cpu_halt,
   output logic wdt_halt,
   output logic internal_reset,
   output logic vector_fetch,
   output idle_reset_pkg::addr_t resume_pc,
   output logic irq_take,
   output logic [2:0] irq_index,
   output logic wake_inline,
   output logic master_interrupt_enable,
   output logic [7:0] source_enable_flags,
   output logic [7:0] pending_request_latch,
   output logic [3:0] bank_selector,
   output logic jump_status_flag,
   output logic [7:0] prescaler
);
   import idle_reset_pkg::*;

   ctl_s st_reg;
   ctl_s st_next;
   logic pin_reset;
   logic trap_hit;
   logic [4:0] cause_now;
   logic cause_any;
   logic setup;
   logic wr;
   logic [7:0] wake_set;
   logic [7:0] clr_mask;
   logic idle_wr;

   // Lowest index wins among set bits
   function automatic logic [2:0] first_set(input logic [7:0] v);
      first_set = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (v[i])
            first_set = 3'(i);
      end
   endfunction

   // Pin synchroniser and machine-cycle counter
   reset_pin_filter u_pin (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .reset_pin_n(reset_pin_n),
      .pin_reset(pin_reset)
   );

   // Address trap region check
   trap_detector u_trap (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr),
      .trap_allow(st_reg.trap_allow),
      .trap_hit(trap_hit)
   );

   // Live reset causes: pin, trap, watchdog, clock, frequency
   assign cause_now = {freq_below | freq_above, sysclk_fault, wdt_reset_req, trap_hit,
                       pin_reset};
   assign cause_any = |cause_now;

   // APB phases; a write lands on the access edge with pready high
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & st_reg.pready;
   assign idle_wr = wr && paddr == `OFS_SYSCTL && pwdata[`SYSCTL_IDLE];

   // Next state of the whole block
   always_comb
   begin
      st_next = st_reg;
      clr_mask = 8'hFF;
      st_next.vec_fetch = 1'b0;
      st_next.irq_take = 1'b0;
      st_next.wake_inline = 1'b0;
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      // Prescaler runs in idle too, as a peripheral
      st_next.presc = st_reg.presc + 8'h01;

      // Cause records are sticky and cleared by writing ones
      if (wr && paddr == `OFS_CAUSE)
         st_next.causes = st_reg.causes & ~pwdata[4:0];
      st_next.causes = st_next.causes | cause_now;

      // Register writes; the CPU is halted in idle so none reach here then
      if (wr && st_reg.mode == ST_RUN)
      begin
         case (paddr)
            `OFS_SYSCTL:
               st_next.mie = pwdata[`SYSCTL_MIE];
            `OFS_TRAP:
            begin
               if (pwdata[15:8] == `TRAP_KEY)
                  st_next.trap_allow = pwdata[`TRAP_ALLOW];
            end
            `OFS_ENABLE:
               st_next.enables = pwdata[7:0];
            `OFS_PENDING:
               clr_mask = pwdata[7:0];
            `OFS_CORE:
            begin
               st_next.bank = pwdata[3:0];
               st_next.jump = pwdata[`CORE_JUMP];
            end
            default:
               st_next.mie = st_reg.mie;
         endcase
      end

      // Idle request, wake and watchdog precedence
      wake_set = st_reg.pending & st_reg.enables;
      case (st_reg.mode)
         ST_RESET:
            st_next.mode = ST_RESET;
         ST_RUN:
         begin
            if (idle_wr)
            begin
               if (st_reg.pending[0] | irq_src[0])
               begin
                  st_next.irq_take = 1'b1;
                  st_next.irq_index = 3'h0;
                  clr_mask[0] = 1'b0;
               end
               else
               begin
                  st_next.mode = ST_IDLE;
                  st_next.resume_pc = next2_pc;
               end
            end
         end
         ST_IDLE:
         begin
            if (wake_set != 8'h00)
            begin
               st_next.mode = ST_RUN;
               if (st_reg.mie)
               begin
                  st_next.irq_take = 1'b1;
                  st_next.irq_index = first_set(wake_set);
                  clr_mask[first_set(wake_set)] = 1'b0;
               end
               else
                  st_next.wake_inline = 1'b1;
            end
         end
         default:
            st_next.mode = ST_RESET;
      endcase

      // New requests win over a clear in the same cycle
      st_next.pending = (st_reg.pending & clr_mask) | irq_src;
      st_next.halt = st_next.mode == ST_IDLE;

      // Internal reset holds while a cause remains and for a tail after
      if (cause_any)
         st_next.hold = `RST_HOLD_CYC;
      else if (st_reg.hold != 4'h0)
         st_next.hold = st_reg.hold - 4'h1;
      st_next.rst_out = cause_any | (st_reg.hold > 4'h1);

      // Any reset, pin included during idle, reinitialises core state;
      // a live cause acts in the same cycle as internal_reset rises
      if (st_reg.rst_out || cause_any)
      begin
         st_next.mode = ST_RESET;
         st_next.bank = `BANK_RST;
         st_next.jump = `JUMP_RST;
         st_next.enables = `ENABLE_RST;
         st_next.presc = `PRESC_RST;
         st_next.pending = 8'h00;
         st_next.mie = 1'b0;
         st_next.trap_allow = 1'b1;
         st_next.halt = 1'b0;
         st_next.irq_take = 1'b0;
         st_next.wake_inline = 1'b0;
         // Stack pointer, general registers and result flags live in the CPU untouched
      end
      if (st_reg.rst_out && !st_next.rst_out)
      begin
         st_next.mode = ST_RUN;
         st_next.vec_fetch = 1'b1;
      end

      // Read data prepared in setup, answered in the first access cycle
      if (setup)
      begin
         st_next.pready = 1'b1;
         st_next.prdata = 32'h0000_0000;
         case (paddr)
            `OFS_SYSCTL:
               st_next.prdata = {29'h0, st_reg.mode == ST_IDLE, st_reg.mie, 1'b0};
            `OFS_TRAP:
               st_next.prdata = {31'h0, st_reg.trap_allow};
            `OFS_ENABLE:
               st_next.prdata = {24'h0, st_reg.enables};
            `OFS_PENDING:
               st_next.prdata = {24'h0, st_reg.pending};
            `OFS_CAUSE:
               st_next.prdata = {21'h0, st_reg.mode, 3'h0, st_reg.causes};
            `OFS_CORE:
               st_next.prdata = {16'h0, st_reg.presc, 3'h0, st_reg.jump, st_reg.bank};
            default:
               st_next.pslverr = 1'b1;
         endcase
      end
   end

   // State register; cause records are left out of power-on reset
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         st_reg <= '{mode: ST_RESET, mie: 1'b0, trap_allow: 1'b1, enables: `ENABLE_RST,
                     pending: 8'h00, causes: 5'h00, bank: `BANK_RST, jump: `JUMP_RST,
                     presc: `PRESC_RST, resume_pc: 20'h00000, hold: `RST_HOLD_CYC,
                     rst_out: 1'b1, vec_fetch: 1'b0, irq_take: 1'b0, irq_index: 3'h0,
                     wake_inline: 1'b0, halt: 1'b0, pready: 1'b0, pslverr: 1'b0,
                     prdata: 32'h0000_0000};
         st_reg.causes <= st_next.causes;
      end
      else
         st_reg <= st_next;
   end

   // Outputs straight from the state register
   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign cpu_halt = st_reg.halt;
   assign wdt_halt = st_reg.halt;
   assign internal_reset = st_reg.rst_out;
   assign vector_fetch = st_reg.vec_fetch;
   assign resume_pc = st_reg.resume_pc;
   assign irq_take = st_reg.irq_take;
   assign irq_index = st_reg.irq_index;
   assign wake_inline = st_reg.wake_inline;
   assign master_interrupt_enable = st_reg.mie;
   assign source_enable_flags = st_reg.enables;
   assign pending_request_latch = st_reg.pending;
   assign bank_selector = st_reg.bank;
   assign jump_status_flag = st_reg.jump;
   assign prescaler = st_reg.presc;

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence idle_ok;
      idle_wr && st_reg.mode == ST_RUN && !st_reg.pending[0] && !irq_src[0] && !st_reg.rst_out
         && !cause_any;
   endsequence

   idle_halts_cpu_a: assert property (idle_ok |=> cpu_halt && wdt_halt)
      else $error("idle entry did not halt");
   idle_holds_state_a: assert property (
      st_reg.mode == ST_IDLE && $past(st_reg.mode) == ST_IDLE |-> $stable(bank_selector)
      && $stable(source_enable_flags) && $stable(resume_pc)) else $error("state moved in idle");
   resume_pc_capture_a: assert property (idle_ok |=> resume_pc == $past(next2_pc))
      else $error("resume address not captured");
   // Wake checks leave out a live reset cause, which wins over a wake
   inline_wake_a: assert property (
      st_reg.mode == ST_IDLE && (pending_request_latch & source_enable_flags) != 8'h00
      && !master_interrupt_enable && !st_reg.rst_out && !cause_any |=> wake_inline
      && !irq_take && (pending_request_latch & source_enable_flags) != 8'h00)
      else $error("bad in-line wake");
   vectored_wake_a: assert property (
      st_reg.mode == ST_IDLE && (pending_request_latch & source_enable_flags) != 8'h00
      && master_interrupt_enable && !st_reg.rst_out && !cause_any |=> irq_take
      && !wake_inline && !cpu_halt)
      else $error("bad vectored wake");
   pin_resets_a: assert property (pin_reset |=> internal_reset && st_reg.mode == ST_RESET)
      else $error("pin reset ignored");
   wdt_blocks_idle_a: assert property (
      idle_wr && st_reg.mode == ST_RUN && st_reg.pending[0] && !st_reg.rst_out && !cause_any
      |=> !cpu_halt && irq_take && irq_index == 3'h0) else $error("idle entered over watchdog");
   cause_combine_a: assert property (cause_any |=> internal_reset)
      else $error("cause did not reset");
   reset_init_a: assert property (internal_reset |=> bank_selector == 4'h0
      && source_enable_flags == 8'h00 && prescaler == 8'h00 && jump_status_flag
      && pending_request_latch == 8'h00) else $error("reset values wrong");
   vector_on_release_a: assert property ($fell(internal_reset) |-> vector_fetch)
      else $error("no vector fetch after reset");
   trap_resets_a: assert property (trap_hit |=> internal_reset)
      else $error("trap hit did not reset");
   reset_hold_a: assert property (internal_reset && cause_any |=> internal_reset [*8])
      else $error("reset released early");

   // Main scenarios reached
   idle_entry_c: cover property (idle_ok ##1 cpu_halt);
   inline_wake_c: cover property (cpu_halt ##1 wake_inline);
   vectored_wake_c: cover property (cpu_halt ##1 irq_take);
   release_c: cover property (internal_reset ##1 vector_fetch);
   pin_reset_c: cover property (pin_reset ##1 internal_reset);
endmodule

// ### test/cpu_model.sv
// Far-side model: CPU fetch stream, idle-entry address and external reset pin.
// Assumes it shares sys_clk with the block and follows its halt and reset outputs.
module cpu_model
   import idle_reset_pkg::*;
(
   input wire logic sys_clk,
   input wire logic cpu_halt,
   input wire logic internal_reset,
   input wire logic run,
   input wire logic trap_go,
   input wire idle_reset_pkg::addr_t trap_addr,
   input wire logic pin_low,
   output logic fetch_valid,
   output idle_reset_pkg::addr_t fetch_addr,
   output idle_reset_pkg::addr_t next2_pc,
   output logic reset_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   addr_t pc;
   // Program counter restarts at the vector target and freezes while halted
   always @(posedge sys_clk)
   begin
      if (internal_reset === 1'b1)
         pc <= 20'h10000;
      else if (run && cpu_halt === 1'b0)
         pc <= pc + 20'h1;
   end
   // No fetches in idle or reset; a commanded fetch may land in a trap region
   assign fetch_valid = cpu_halt === 1'b0 && internal_reset === 1'b0 && (run || trap_go);
   assign fetch_addr = trap_go ? trap_addr : (fetch_valid ? pc : ~pc);
   assign next2_pc = pc + 20'h2;
   // Pin has a pull-up, so a released pin reads high; the bench times the low phase
   assign reset_pin_n = !pin_low;
endmodule

// ### test/testbench.sv
// Self-checking bench for idle mode and reset control over APB.
// Assumes the block's package, constants header and the cpu_model partner.
`include "idle_reset_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import idle_reset_pkg::*;
   logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, reset_pin_n, err;
   logic wdt_reset_req, sysclk_fault, freq_below, freq_above, fetch_valid, cpu_halt, wdt_halt;
   logic internal_reset, vector_fetch, irq_take, wake_inline, master_interrupt_enable;
   logic jump_status_flag, run, trap_go, pin_low;
   logic [7:0] paddr, irq_src, source_enable_flags, pending_request_latch, prescaler, p0;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] irq_index, last_idx;
   logic [3:0] bank_selector;
   addr_t fetch_addr, next2_pc, resume_pc, trap_addr;
   addr_t taddr [3] = '{20'h00100, 20'h00010, 20'h00F10};
   logic [4:0] cbits [4] = '{5'h04, 5'h08, 5'h10, 5'h10};
   int error_cnt = 0, tests_run = 0, cyc = 0, take_n = 0, inline_n = 0, vec_n = 0, halt_n = 0;
   int t0, i0, v0, h0;

   idle_mode_and_reset_control idle_mode_and_reset_control_inst (.sys_clk, .rstn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n,
      .wdt_reset_req, .sysclk_fault, .freq_below, .freq_above, .fetch_valid, .fetch_addr,
      .next2_pc, .irq_src, .cpu_halt, .wdt_halt, .internal_reset, .vector_fetch, .resume_pc,
      .irq_take, .irq_index, .wake_inline, .master_interrupt_enable, .source_enable_flags,
      .pending_request_latch, .bank_selector, .jump_status_flag, .prescaler);
   cpu_model cpu_model_inst (.sys_clk, .cpu_halt, .internal_reset, .run, .trap_go, .trap_addr,
      .pin_low, .fetch_valid, .fetch_addr, .next2_pc, .reset_pin_n);

   // Clock generation
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Event counters for one-cycle pulses and halted cycles, plus the hang limit
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (irq_take === 1'b1)
      begin
         take_n <= take_n + 1;
         last_idx <= irq_index;
      end
      if (wake_inline === 1'b1)
         inline_n <= inline_n + 1;
      if (vector_fetch === 1'b1)
         vec_n <= vec_n + 1;
      if (cpu_halt === 1'b1)
         halt_n <= halt_n + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask

   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      check("pready", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Bounded wait for the internal reset to reach a level
   task automatic wait_rst(input logic v);
      int n;
      n = 0;
      while (internal_reset !== v && n < 60)
      begin
         @(negedge sys_clk);
         n++;
      end
      check("internal_reset", internal_reset, v);
      @(negedge sys_clk);
   endtask

   task automatic pulse_irq(input logic [7:0] m);
      @(posedge sys_clk);
      irq_src <= m;
      @(posedge sys_clk);
      irq_src <= 8'h00;
      repeat (6) @(negedge sys_clk);
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {rstn, psel, penable, pwrite, paddr, pwdata, irq_src, run, trap_go, pin_low} = '0;
      {wdt_reset_req, sysclk_fault, freq_below, freq_above} = 4'h0;
      trap_addr = 20'h00100;
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      wait_rst(1'b0);
      check("vector", vec_n, 1);
      check("core", {bank_selector, jump_status_flag, master_interrupt_enable}, 6'h02);
      check("enables", source_enable_flags, 8'h00);
      check("pending", pending_request_latch, 8'h00);
      apb(1'b0, `OFS_TRAP, 32'h0);
      check("trap allow", rd[0], 1'b1);
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      apb(1'b1, `OFS_CAUSE, 32'h1F);
      $display("reset defaults done");
      apb(1'b1, `OFS_ENABLE, 32'h28);
      apb(1'b1, `OFS_SYSCTL, 32'h1);
      @(negedge sys_clk);
      check("halts", {cpu_halt, wdt_halt}, 2'b11);
      check("resume", resume_pc, 20'h10002);
      p0 = prescaler;
      repeat (3) @(negedge sys_clk);
      check("presc runs", prescaler !== p0, 1'b1);
      check("kept", {bank_selector, source_enable_flags}, 12'h028);
      {t0, i0} = {take_n, inline_n};
      pulse_irq(8'h08);
      check("inline", inline_n - i0, 1);
      check("inline take", take_n - t0, 0);
      check("wake latch", {cpu_halt, pending_request_latch}, 9'h008);
      apb(1'b1, `OFS_PENDING, 32'hF7);
      @(negedge sys_clk);
      check("cleared", pending_request_latch, 8'h00);
      $display("inline wake done");
      {t0, h0} = {take_n, halt_n};
      apb(1'b1, `OFS_SYSCTL, 32'h3);
      pulse_irq(8'h20);
      check("vectored", take_n - t0, 1);
      check("vec index", last_idx, 3'd5);
      check("vec state", {cpu_halt, pending_request_latch}, 9'h000);
      check("halted", halt_n > h0, 1'b1);
      pulse_irq(8'h01);
      {t0, h0} = {take_n, halt_n};
      apb(1'b1, `OFS_SYSCTL, 32'h3);
      repeat (4) @(negedge sys_clk);
      check("wdt no halt", halt_n - h0, 0);
      check("wdt first", take_n - t0, 1);
      check("wdt index", {last_idx, pending_request_latch[0]}, 4'h0);
      $display("vectored and watchdog done");
      apb(1'b1, `OFS_SYSCTL, 32'h1);
      pulse_irq(8'h80);
      v0 = vec_n;
      @(posedge sys_clk);
      pin_low <= 1'b1;
      repeat (8) @(posedge sys_clk);
      pin_low <= 1'b0;
      repeat (6) @(negedge sys_clk);
      check("short pin", {internal_reset, cpu_halt}, 2'b01);
      @(posedge sys_clk);
      pin_low <= 1'b1;
      repeat (16) @(posedge sys_clk);
      wait_rst(1'b1);
      check("idle left", cpu_halt, 1'b0);
      @(posedge sys_clk);
      pin_low <= 1'b0;
      wait_rst(1'b0);
      check("vector again", vec_n - v0, 1);
      check("init", {source_enable_flags, pending_request_latch}, 16'h0);
      check("init core", {bank_selector, jump_status_flag, master_interrupt_enable}, 6'h02);
      apb(1'b0, `OFS_CAUSE, 32'h0);
      check("pin cause", rd[10:0], 11'h201);
      apb(1'b1, `OFS_CAUSE, 32'h1F);
      $display("pin reset done");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge sys_clk);
         {freq_above, freq_below, sysclk_fault, wdt_reset_req} <= 4'h1 << i;
         repeat (20) @(negedge sys_clk);
         check("cause held", internal_reset, 1'b1);
         @(posedge sys_clk);
         {freq_above, freq_below, sysclk_fault, wdt_reset_req} <= 4'h0;
         repeat (10) @(negedge sys_clk);
         check("hold", internal_reset, 1'b1);
         wait_rst(1'b0);
         apb(1'b0, `OFS_CAUSE, 32'h0);
         check("cause", rd[4:0], cbits[i]);
         apb(1'b1, `OFS_CAUSE, 32'h1F);
      end
      run <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge sys_clk);
         trap_addr <= taddr[i];
         trap_go <= 1'b1;
         @(posedge sys_clk);
         trap_go <= 1'b0;
         wait_rst(1'b1);
         wait_rst(1'b0);
         apb(1'b0, `OFS_CAUSE, 32'h0);
         check("trap cause", rd[4:0], 5'h02);
         apb(1'b1, `OFS_CAUSE, 32'h1F);
      end
      apb(1'b1, `OFS_TRAP, 32'h0);
      apb(1'b0, `OFS_TRAP, 32'h0);
      check("no key", rd[0], 1'b1);
      apb(1'b1, `OFS_TRAP, 32'hA500);
      apb(1'b0, `OFS_TRAP, 32'h0);
      check("prohibit", rd[0], 1'b0);
      @(posedge sys_clk);
      trap_addr <= taddr[0];
      trap_go <= 1'b1;
      @(posedge sys_clk);
      trap_go <= 1'b0;
      repeat (6) @(negedge sys_clk);
      check("ram runs", internal_reset, 1'b0);
      $display("causes and trap done");
      @(posedge sys_clk);
      wdt_reset_req <= 1'b1;
      @(posedge sys_clk);
      wdt_reset_req <= 1'b0;
      wait_rst(1'b1);
      wait_rst(1'b0);
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      wait_rst(1'b0);
      apb(1'b0, `OFS_CAUSE, 32'h0);
      check("cause kept", rd[2], 1'b1);
      $display("power-on record done");
      wrap_up();
   end
endmodule
